/* File: pkg/cte_trap_map.svh */
`ifndef CTE_TRAP_MAP_SVH
`define CTE_TRAP_MAP_SVH

// Trap causes, index 0 is the highest priority
`define CTE_NUM_CAUSE 10
`define CTE_C_HALT_INSTR 4'h0
`define CTE_C_ODD_ADDR 4'h1
`define CTE_C_MMU_ERR 4'h2
`define CTE_C_TIMEOUT 4'h3
`define CTE_C_PARITY 4'h4
`define CTE_C_TRAP_INSTR 4'h5
`define CTE_C_TRACE 4'h6
`define CTE_C_STACK_OVF 4'h7
`define CTE_C_POWER_FAIL 4'h8
`define CTE_C_CONSOLE_HALT 4'h9

// Fixed stack limit, overflow when the pointer goes below it
`define CTE_STACK_LIMIT 16'h0100
// Offset from a trap vector to its status word
`define CTE_SW_OFFSET 16'h0002

`endif

/* File: pkg/cte_pkg.sv */
package cte_pkg;

  typedef enum logic [2:0] {
    CTE_ST_RUN = 3'b001,
    CTE_ST_PUSH1 = 3'b010,
    CTE_ST_PUSH2 = 3'b100
  } cte_state_t;

  typedef struct packed {
    cte_state_t state;
    logic [15:0] vec;
    logic odd_pend;
    logic tmo_pend;
    logic stk_pend;
    logic svc_first;
    logic trap_take;
    logic [3:0] trap_cause;
    logic intr_grant;
    logic fetch_go;
    logic illegal;
    logic pc_inc;
    logic reg_inc;
    logic sw_from_vec;
    logic [15:0] sw_addr;
  } cte_regs_t;

endpackage

/* File: design/cte_trap_unit.sv */
// What this block does
// - PC nonexistent-memory fetch error: PC unincremented
// - Odd mode 2: unincremented except move, previous-space move
// - Nonexistent mode 2: unincremented except move-dest, previous-space move
// - Higher interrupt served before service routine starts
// - Fixed trap priority, halt instruction highest
// - Decode implemented instruction set, flag others
// - Violation between pushes: status from vector plus two
// - Fixed stack limit checks, overflow raises trap
// - Trace bit set by interrupt return traps immediately
// - After trap return, next instruction runs first
`timescale 1ns/1ps
`default_nettype none
`include "cte_trap_map.svh"

module cte_trap_unit (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Instruction in progress
  input wire logic [15:0] i_opcode,
  input wire logic i_boundary,
  input wire logic i_ret_trap,
  input wire logic i_t_bit,
  // External trap requests, one bit per cause
  input wire logic [9:0] i_trap_req,
  input wire logic i_intr_req,
  // Bus errors
  input wire logic i_bus_err,
  input wire logic i_err_odd,
  input wire logic i_err_pc_fetch,
  input wire logic i_err_mode2,
  input wire logic i_err_dest,
  // Stack checks and trap sequence
  input wire logic i_sp_check,
  input wire logic [15:0] i_sp,
  input wire logic [15:0] i_vector,
  input wire logic i_push_done,
  input wire logic i_mmu_viol,
  // Sequencing outputs
  output logic o_trap_take,
  output logic [3:0] o_trap_cause,
  output logic o_intr_grant,
  output logic o_fetch_go,
  output logic o_svc_first,
  output logic o_illegal,
  // Register update outputs
  output logic o_pc_inc,
  output logic o_reg_inc,
  // Status word source
  output logic o_sw_from_vec,
  output logic [15:0] o_sw_addr
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic cte_implemented(input logic [15:0] op);
    logic ok;
    ok = 1'b0;
    if (op[14:12] != 3'h0 && op[14:12] != 3'h7) begin
      ok = 1'b1;
    end else if (op[15:12] == 4'h7) begin
      ok = (op[11:9] <= 3'h4) || (op[11:9] == 3'h7);
    end else if (op[15:12] == 4'h8) begin
      ok = (op[11:6] <= 6'h33) || (op[11:6] == 6'h34) || (op[11:6] == 6'h37);
    end else if (op[15:12] == 4'h0) begin
      if (op[11:6] == 6'h00) begin
        ok = (op[5:0] <= 6'h06);
      end else if (op[11:6] == 6'h02) begin
        ok = (op[5:3] == 3'h0) || op[5];
      end else begin
        ok = (op[11:6] <= 6'h37);
      end
    end
    return ok;
  endfunction

  function automatic logic cte_is_move(input logic [15:0] op);
    return op[15:12] == 4'h1;
  endfunction

  function automatic logic cte_is_prev_move(input logic [15:0] op);
    return op[15:6] == 10'h036;
  endfunction

  function automatic logic [3:0] cte_first(input logic [9:0] req);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = `CTE_NUM_CAUSE - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  cte_pkg::cte_regs_t r;
  cte_pkg::cte_regs_t next_r;
  logic [9:0] req;
  logic trace_ok;

  always_comb begin
    next_r = r;
    next_r.trap_take = 1'b0;
    next_r.intr_grant = 1'b0;
    next_r.fetch_go = 1'b0;
    // Trace waits one instruction when the finished one was a trap return
    trace_ok = i_t_bit && !i_ret_trap;
    req = i_trap_req;
    req[`CTE_C_ODD_ADDR] = i_trap_req[`CTE_C_ODD_ADDR] | r.odd_pend;
    req[`CTE_C_TIMEOUT] = i_trap_req[`CTE_C_TIMEOUT] | r.tmo_pend;
    req[`CTE_C_STACK_OVF] = i_trap_req[`CTE_C_STACK_OVF] | r.stk_pend;
    req[`CTE_C_TRACE] = i_trap_req[`CTE_C_TRACE] | trace_ok;

    // ----------------------------------------
    // Bus errors and register increments
    // ----------------------------------------
    if (i_bus_err) begin
      if (i_err_odd) begin
        next_r.odd_pend = 1'b1;
      end else begin
        next_r.tmo_pend = 1'b1;
      end
      if (i_err_pc_fetch) begin
        next_r.pc_inc = 1'b0;
      end else begin
        next_r.pc_inc = 1'b1;
      end
      if (!i_err_mode2) begin
        next_r.reg_inc = 1'b1;
      end else if (i_err_odd) begin
        next_r.reg_inc = cte_is_move(i_opcode) || cte_is_prev_move(i_opcode);
      end else begin
        next_r.reg_inc = (cte_is_move(i_opcode) && i_err_dest)
                         || cte_is_prev_move(i_opcode);
      end
    end

    // ----------------------------------------
    // Stack limit
    // ----------------------------------------
    if (i_sp_check && i_sp < `CTE_STACK_LIMIT) begin
      next_r.stk_pend = 1'b1;
    end

    // ----------------------------------------
    // Instruction boundary arbitration
    // ----------------------------------------
    if (i_boundary) begin
      next_r.illegal = !cte_implemented(i_opcode);
      if (req != 10'h000) begin
        next_r.trap_take = 1'b1;
        next_r.trap_cause = cte_first(req);
        next_r.svc_first = 1'b1;
        next_r.state = cte_pkg::CTE_ST_PUSH1;
        case (cte_first(req))
          `CTE_C_ODD_ADDR: next_r.odd_pend = 1'b0;
          `CTE_C_TIMEOUT: next_r.tmo_pend = 1'b0;
          `CTE_C_STACK_OVF: next_r.stk_pend = 1'b0;
          default: next_r.odd_pend = r.odd_pend;
        endcase
        // A fresh event in the same cycle keeps its flag
        if (i_bus_err && i_err_odd) begin
          next_r.odd_pend = 1'b1;
        end
        if (i_bus_err && !i_err_odd) begin
          next_r.tmo_pend = 1'b1;
        end
        if (i_sp_check && i_sp < `CTE_STACK_LIMIT) begin
          next_r.stk_pend = 1'b1;
        end
      end else if (i_intr_req) begin
        next_r.intr_grant = 1'b1;
        next_r.svc_first = 1'b1;
        next_r.state = cte_pkg::CTE_ST_PUSH1;
      end else begin
        next_r.fetch_go = 1'b1;
        next_r.svc_first = 1'b0;
      end
    end

    // ----------------------------------------
    // Trap sequence stack pushes
    // ----------------------------------------
    case (r.state)
      cte_pkg::CTE_ST_RUN: begin
        next_r.sw_from_vec = r.sw_from_vec;
      end
      cte_pkg::CTE_ST_PUSH1: begin
        next_r.sw_from_vec = 1'b0;
        if (i_push_done) begin
          next_r.vec = i_vector;
          next_r.state = cte_pkg::CTE_ST_PUSH2;
        end
      end
      cte_pkg::CTE_ST_PUSH2: begin
        if (i_mmu_viol) begin
          next_r.sw_from_vec = 1'b1;
          next_r.sw_addr = r.vec + `CTE_SW_OFFSET;
          next_r.state = cte_pkg::CTE_ST_RUN;
        end else if (i_push_done) begin
          next_r.state = cte_pkg::CTE_ST_RUN;
        end
      end
      default: begin
        next_r.state = cte_pkg::CTE_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '{state: cte_pkg::CTE_ST_RUN, vec: 16'h0000, odd_pend: 1'b0,
             tmo_pend: 1'b0, stk_pend: 1'b0, svc_first: 1'b0,
             trap_take: 1'b0, trap_cause: 4'h0, intr_grant: 1'b0,
             fetch_go: 1'b0, illegal: 1'b0, pc_inc: 1'b1, reg_inc: 1'b1,
             sw_from_vec: 1'b0, sw_addr: 16'h0000};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_trap_take = r.trap_take;
  assign o_trap_cause = r.trap_cause;
  assign o_intr_grant = r.intr_grant;
  assign o_fetch_go = r.fetch_go;
  assign o_svc_first = r.svc_first;
  assign o_illegal = r.illegal;
  assign o_pc_inc = r.pc_inc;
  assign o_reg_inc = r.reg_inc;
  assign o_sw_from_vec = r.sw_from_vec;
  assign o_sw_addr = r.sw_addr;

endmodule

`default_nettype wire

/* File: verification/cte_trap_unit_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module cte_trap_unit_chk (
  // Watched ports
  input wire logic i_clk, i_rst_b, i_boundary, i_ret_trap, i_intr_req, i_bus_err, i_err_mode2,
  input wire logic i_err_pc_fetch, i_mmu_viol, o_trap_take, o_intr_grant, o_fetch_go,
  input wire logic o_pc_inc, o_reg_inc, o_sw_from_vec, i_t_bit,
  input wire logic [15:0] i_opcode,
  input wire logic [9:0] i_trap_req,
  input wire logic [3:0] o_trap_cause
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_top; i_boundary && i_trap_req[0] |=> o_trap_take && o_trap_cause == 4'h0; endproperty
  a_top: assert property (p_top) else $error("top cause lost");
  property p_trap; i_boundary && i_trap_req != 10'h000 |=> o_trap_take && !o_fetch_go; endproperty
  a_trap: assert property (p_trap) else $error("trap not taken");
  property p_grant; o_intr_grant |-> $past(i_intr_req) && $past(i_boundary); endproperty
  a_grant: assert property (p_grant) else $error("grant without request");
  property p_fetch; o_fetch_go |-> !$past(i_intr_req); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch while interrupt pends");
  property p_pc; i_bus_err && i_err_pc_fetch |=> !o_pc_inc; endproperty
  a_pc: assert property (p_pc) else $error("pc incremented");
  property p_prev_move; i_bus_err && i_err_mode2 && i_opcode[15:6] == 10'h036 |=> o_reg_inc;
  endproperty
  a_prev_move: assert property (p_prev_move) else $error("register not incremented");
  property p_sw; $rose(o_sw_from_vec) |-> $past(i_mmu_viol); endproperty
  a_sw: assert property (p_sw) else $error("status source without violation");
  property p_ret; i_boundary && i_ret_trap && !i_trap_req[6]
    |=> !(o_trap_take && o_trap_cause == 4'h6); endproperty
  a_ret: assert property (p_ret) else $error("trace right after trap return");
  property p_trace; i_boundary && i_t_bit && !i_ret_trap |=> o_trap_take; endproperty
  a_trace: assert property (p_trace) else $error("trace bit set but no trap");
  c_trace: cover property (o_trap_take && o_trap_cause == 4'h6);
  c_grant: cover property (o_intr_grant);
  c_sw: cover property ($rose(o_sw_from_vec));
  c_ret: cover property (i_boundary && i_ret_trap && i_t_bit);
endmodule

bind cte_trap_unit cte_trap_unit_chk i_cte_trap_unit_chk (.i_clk, .i_rst_b, .i_boundary,
  .i_ret_trap, .i_intr_req, .i_bus_err, .i_err_mode2, .i_err_pc_fetch, .i_mmu_viol, .o_trap_take,
  .o_intr_grant, .o_fetch_go, .o_pc_inc, .o_reg_inc, .o_sw_from_vec, .i_t_bit, .i_opcode,
  .i_trap_req, .o_trap_cause);

`default_nettype wire

/* File: verification/cte_trap_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module cte_trap_unit_tb;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_boundary = 1'b0, i_ret_trap = 1'b0, i_t_bit = 1'b0;
  logic i_intr_req = 1'b0, i_bus_err = 1'b0, i_err_odd = 1'b0, i_err_pc_fetch = 1'b0;
  logic i_err_mode2 = 1'b0, i_err_dest = 1'b0, i_sp_check = 1'b0, i_push_done = 1'b0;
  logic i_mmu_viol = 1'b0;
  logic [15:0] i_opcode = 16'h0A00, i_sp = 16'h1000, i_vector = 16'h0000, o_sw_addr;
  logic [9:0] i_trap_req = 10'h000;
  logic o_trap_take, o_intr_grant, o_fetch_go, o_svc_first, o_illegal, o_pc_inc, o_reg_inc;
  logic o_sw_from_vec;
  logic [3:0] o_trap_cause;
  int err_count = 0, compares = 0, cyc = 0;

  cte_trap_unit i_cte_trap_unit (.i_clk, .i_rst_b, .i_opcode, .i_boundary, .i_ret_trap, .i_t_bit,
    .i_trap_req, .i_intr_req, .i_bus_err, .i_err_odd, .i_err_pc_fetch, .i_err_mode2, .i_err_dest,
    .i_sp_check, .i_sp, .i_vector, .i_push_done, .i_mmu_viol, .o_trap_take, .o_trap_cause,
    .o_intr_grant, .o_fetch_go, .o_svc_first, .o_illegal, .o_pc_inc, .o_reg_inc, .o_sw_from_vec,
    .o_sw_addr);

  always #5 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      err_count++;
    end
  endtask

  // One arbitration; a trap or grant is followed by its two stack pushes
  task automatic arb(input logic [9:0] q, input logic rt, t, input logic [2:0] er,
                     input logic [3:0] ec);
    @(posedge i_clk);
    i_boundary <= 1'b1;
    i_trap_req <= q;
    i_ret_trap <= rt;
    i_t_bit <= t;
    @(posedge i_clk);
    i_boundary <= 1'b0;
    i_trap_req <= 10'h000;
    i_ret_trap <= 1'b0;
    i_t_bit <= 1'b0;
    #1;
    chk(16'({o_trap_take, o_intr_grant, o_fetch_go}), 16'(er));
    if (er[2]) chk(16'(o_trap_cause), 16'(ec));
    if (er[2] | er[1]) begin
      @(posedge i_clk);
      i_push_done <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_push_done <= 1'b0;
    end
  endtask

  task automatic t_prio();
    for (int k = 0; k < 10; k++) arb(10'h3FF << k, 1'b0, 1'b0, 3'b100, 4'(k));
    i_intr_req <= 1'b1;
    arb(10'h200, 1'b0, 1'b0, 3'b100, 4'h9);
    arb(10'h000, 1'b0, 1'b0, 3'b010, 4'h0);
    chk(16'(o_svc_first), 16'h0001);
    arb(10'h000, 1'b0, 1'b0, 3'b010, 4'h0);
    i_intr_req <= 1'b0;
    arb(10'h000, 1'b0, 1'b0, 3'b001, 4'h0);
    $display("priority test done");
  endtask

  task automatic t_buserr();
    logic [15:0] ops [8] = '{16'h0A00, 16'h0A10, 16'h1411, 16'h0D90, 16'h1411, 16'h1411,
                             16'h0D90, 16'h0A10};
    logic [3:0] row [8] = '{4'h4, 4'h8, 4'h9, 4'h9, 4'h0, 4'h3, 4'h1, 4'h2};
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk);
      i_bus_err <= 1'b1;
      {i_err_odd, i_err_pc_fetch, i_err_dest} <= row[k][3:1];
      i_err_mode2 <= ~row[k][2];
      i_opcode <= ops[k];
      @(posedge i_clk);
      i_bus_err <= 1'b0;
      #1;
      chk(16'(o_pc_inc), 16'(!row[k][2]));
      if (!row[k][2]) chk(16'(o_reg_inc), 16'(row[k][0]));
      arb(10'h000, 1'b0, 1'b0, 3'b100, row[k][3] ? 4'h1 : 4'h3);
    end
    $display("bus error test done");
  endtask

  task automatic t_misc();
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_sp_check <= 1'b1;
      i_sp <= k ? 16'h0100 : 16'h00FF;
      @(posedge i_clk);
      i_sp_check <= 1'b0;
      arb(10'h000, 1'b0, 1'b0, k ? 3'b001 : 3'b100, 4'h7);
    end
    arb(10'h000, 1'b0, 1'b1, 3'b100, 4'h6);
    arb(10'h000, 1'b1, 1'b1, 3'b001, 4'h0);
    arb(10'h000, 1'b0, 1'b1, 3'b100, 4'h6);
    i_opcode <= 16'hF000;
    arb(10'h000, 1'b0, 1'b1, 3'b100, 4'h6);
    chk(16'(o_illegal), 16'h0001);
    i_opcode <= 16'h8D00;
    arb(10'h000, 1'b0, 1'b0, 3'b001, 4'h0);
    chk(16'(o_illegal), 16'h0000);
    $display("stack trace decode test done");
  endtask

  task automatic t_mmu();
    @(posedge i_clk);
    i_boundary <= 1'b1;
    i_trap_req <= 10'h020;
    @(posedge i_clk);
    i_boundary <= 1'b0;
    i_trap_req <= 10'h000;
    i_push_done <= 1'b1;
    i_vector <= 16'h0024;
    @(posedge i_clk);
    i_push_done <= 1'b0;
    i_mmu_viol <= 1'b1;
    @(posedge i_clk);
    i_mmu_viol <= 1'b0;
    #1;
    chk(o_sw_addr, 16'h0026);
    chk(16'(o_sw_from_vec), 16'h0001);
    $display("violation test done");
  endtask

  task automatic end_sim();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(16'({o_pc_inc, o_reg_inc, o_sw_from_vec, o_illegal, o_svc_first}), 16'h0018);
    chk(o_sw_addr, 16'h0000);
    t_prio();
    t_buserr();
    t_misc();
    t_mmu();
    end_sim();
  end
endmodule

`default_nettype wire
